//--- src/sep_dev.sv
// device end: sixteen 16-bit nonvolatile registers behind a serial command port
// assumes serial lines synchronous to i_clk and a host much slower than i_clk
`timescale 1ns/100ps
`default_nettype none
`include "sep_map.svh"

// Behaviour
// - all bits move on serial clock rise
// - start bit is zero-to-one after select rises
// - one instruction per select rising edge
// - read opcode plus address drives register out
// - read sends dummy zero then 16 bits
// - serial input ignored during read output
// - after 16 bits output mirrors serial input
// - host holds select low one clock after read
// - write sends 16 data bits, then 10 ms low
// - erase and bulk ops run during low pulse
// - write-all exists but is unsupported by host
// - program enable before, disable after programming
// - select fall starts programming, rise stops it
// - programming low time at most 30 ms
// - host may stop clock while programming
// - serial clock at most 250 kHz, 25-75% duty
// - output driven only while selected in read
// - host releases shared line after last bit
module sep_dev (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // serial lines
  sep_if.dev link,
  // status
  output logic o_prog_en,
  output logic o_hv_on
);
  import sep_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_DATA,
    ST_READ,
    ST_ECHO,
    ST_DONE
  } sep_dev_state_e;

  sep_dev_state_e state, next_state;
  logic [4:0] cnt, next_cnt;
  sep_word_t sh, next_sh;
  logic [3:0] addr, next_addr;
  logic dout, next_dout;
  logic prog_en, next_prog_en;
  logic hv, next_hv, program_all_cmd_q, next_program_all_cmd;
  sep_op_e pend, next_pend;
  sep_word_t pdata, next_pdata;
  logic sck_q, cs_q;
  logic sck_rise, cs_rise, cs_fall;
  logic [7:0] cmd_byte;
  logic mem_we, mem_all;
  sep_word_t mem_wdata;
  sep_word_t mem [16];

  ////////////////////////////////////////////////////////////////
  // edge detection on the host-driven lines
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sck_q <= 1'b0;
      cs_q <= 1'b0;
    end
    else
    begin
      sck_q <= link.serial_clock;
      cs_q <= link.cs;
    end
  end

  assign sck_rise = link.serial_clock && !sck_q;
  assign cs_rise = link.cs && !cs_q;
  assign cs_fall = !link.cs && cs_q;
  assign cmd_byte = {sh[6:0], link.serial_in};

  ////////////////////////////////////////////////////////////////
  // command sequencer
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_sh = sh;
    next_addr = addr;
    next_dout = dout;
    next_prog_en = prog_en;
    next_pend = pend;
    next_pdata = pdata;
    if (!link.cs)
    begin
      // deselect always program_disable_cmd_alias the instruction
      next_state = ST_IDLE;
      next_cnt = '0;
      next_dout = 1'b0;
    end
    else if (state == ST_ECHO)
      next_dout = link.serial_in;
    else if (sck_rise)
    begin
      unique case (state)
        ST_IDLE:
        begin
          // first high sample after select is the start bit
          if (link.serial_in)
          begin
            next_state = ST_CMD;
            next_cnt = '0;
          end
        end
        ST_CMD:
        begin
          next_sh = {sh[14:0], link.serial_in};
          next_cnt = cnt + 5'd1;
          if (cnt == 5'(`SEP_CMD_BITS - 2))
          begin
            next_cnt = '0;
            next_addr = cmd_byte[3:0];
            next_state = ST_DONE;
            unique case (cmd_byte[7:4])
              `SEP_OPC_READ:
              begin
                next_sh = mem[cmd_byte[3:0]];
                next_dout = 1'b0;
                next_state = ST_READ;
              end
              `SEP_OPC_WRITE:
                next_state = ST_DATA;
              `SEP_OPC_ERASE:
              begin
                if (prog_en)
                  next_pend = SEP_OP_ERASE;
              end
              `SEP_OPC_SPECIAL:
              begin
                if (cmd_byte[3:0] == `SEP_PROGRAM_ENABLE_CMD)
                  next_prog_en = 1'b1;
                else if (cmd_byte[3:0] == `SEP_PROGRAM_DISABLE_CMD)
                  next_prog_en = 1'b0;
                else if (cmd_byte[3:0] == `SEP_PROGRAM_ALL_CMD)
                  next_state = ST_DATA;
                else if (cmd_byte[3:0] == `SEP_CLEAR_ALL_CMD && prog_en)
                  next_pend = SEP_OP_ERASE_ALL;
              end
              default:
                next_state = ST_DONE; // unknown opcodes do nothing
            endcase
          end
        end
        ST_DATA:
        begin
          next_sh = {sh[14:0], link.serial_in};
          next_cnt = cnt + 5'd1;
          if (cnt == 5'(`SEP_DATA_BITS - 1))
          begin
            next_cnt = '0;
            next_state = ST_DONE;
            next_pdata = {sh[14:0], link.serial_in};
            if (prog_en)
              next_pend = program_all_cmd_q ? SEP_OP_WRITE_ALL : SEP_OP_WRITE;
          end
        end
        ST_READ:
        begin
          // last data bit stands until the rise after it, only then does the line mirror serial input
          next_dout = (cnt == 5'(`SEP_DATA_BITS)) ? link.serial_in : sh[15];
          next_sh = {sh[14:0], 1'b0};
          next_cnt = cnt + 5'd1;
          if (cnt == 5'(`SEP_DATA_BITS))
            next_state = ST_ECHO;
        end
        ST_DONE:
          next_state = ST_DONE;
        default:
          next_state = ST_IDLE;
      endcase
    end
    // programming consumes the armed operation at deselect
    if (cs_fall || cs_rise)
      next_pend = SEP_OP_NONE;
  end
  // flags which data frame belongs to write-all
  always_comb
  begin
    next_program_all_cmd = program_all_cmd_q;
    if (!link.cs)
      next_program_all_cmd = 1'b0;
    else if (sck_rise && state == ST_CMD && cnt == 5'(`SEP_CMD_BITS - 2))
      next_program_all_cmd = (cmd_byte == {`SEP_OPC_SPECIAL, `SEP_PROGRAM_ALL_CMD});
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state <= ST_IDLE;
      cnt <= '0;
      sh <= '0;
      addr <= '0;
      dout <= 1'b0;
      prog_en <= 1'b0;
      pend <= SEP_OP_NONE;
      pdata <= '0;
      program_all_cmd_q <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      sh <= next_sh;
      addr <= next_addr;
      dout <= next_dout;
      prog_en <= next_prog_en;
      pend <= next_pend;
      pdata <= next_pdata;
      program_all_cmd_q <= next_program_all_cmd;
    end
  end

  ////////////////////////////////////////////////////////////////
  // high-voltage window and cell update
  always_comb
  begin
    next_hv = hv;
    mem_we = 1'b0;
    mem_all = 1'b0;
    mem_wdata = pdata;
    if (cs_fall && pend != SEP_OP_NONE && prog_en)
    begin
      next_hv = 1'b1;
      mem_we = 1'b1;
      mem_all = (pend == SEP_OP_WRITE_ALL) || (pend == SEP_OP_ERASE_ALL);
      if (pend == SEP_OP_ERASE || pend == SEP_OP_ERASE_ALL)
        mem_wdata = `SEP_ERASED;
    end
    else if (cs_rise)
      next_hv = 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      hv <= 1'b0;
    else
      hv <= next_hv;
  end

  // cells are nonvolatile: no reset; the cell is committed at the fall so a short pulse still lands
  always_ff @(posedge i_clk)
  begin
    for (int i = 0; i < 16; i++)
    begin
      if (mem_we && (mem_all || addr == 4'(i)))
        mem[i] <= mem_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs
  assign link.dout = dout;
  assign link.dout_oe = link.cs && cs_q && (state == ST_READ || state == ST_ECHO);
  assign o_prog_en = prog_en;
  assign o_hv_on = hv;
endmodule

`default_nettype wire

//--- pkg/sep_map.svh
// constants of the serial register-memory command port: opcodes, bit counts, timing
// assumes a 100 MHz system clock; included by bare name
`ifndef SEP_MAP_SVH
`define SEP_MAP_SVH

// system clock and serial clock timing
`define SEP_CLK_NS 10
`define SEP_SCK_NS 4000
`define SEP_HALF_CYC ((`SEP_SCK_NS / 2) / `SEP_CLK_NS)
`define SEP_PROG_MS 10
`define SEP_PROG_CYC ((`SEP_PROG_MS * 1000000) / `SEP_CLK_NS)

// frame sizes
`define SEP_CMD_BITS 9
`define SEP_DATA_BITS 16
`define SEP_READ_OUT_BITS 17
`define SEP_ADDR_BITS 4

// opcode nibble after the start bit, then address or sub-code nibble
`define SEP_OPC_READ 4'h0
`define SEP_OPC_WRITE 4'h8
`define SEP_OPC_ERASE 4'h4
`define SEP_OPC_SPECIAL 4'hC
`define SEP_PROGRAM_ENABLE_CMD 4'h1
`define SEP_PROGRAM_DISABLE_CMD 4'h2
`define SEP_PROGRAM_ALL_CMD 4'h4
`define SEP_CLEAR_ALL_CMD 4'h5

// cell value after erase
`define SEP_ERASED 16'hFFFF

`endif

//--- pkg/sep_pkg.sv
// types shared by both program_disable_cmd_alias of the serial register-memory command port
// constants live in sep_map.svh
package sep_pkg;

  // commands the host end accepts from its user
  typedef enum logic [2:0] {
    SEP_CMD_READ,
    SEP_CMD_WRITE,
    SEP_CMD_ERASE,
    SEP_CMD_CLEAR_ALL,
    SEP_CMD_PROGRAM_ALL,
    SEP_CMD_PROG_EN,
    SEP_CMD_PROG_DIS
  } sep_cmd_e;

  // programming operation armed in the device, run while select is low
  typedef enum logic [2:0] {
    SEP_OP_NONE,
    SEP_OP_WRITE,
    SEP_OP_ERASE,
    SEP_OP_WRITE_ALL,
    SEP_OP_ERASE_ALL
  } sep_op_e;

  typedef logic [15:0] sep_word_t;

endpackage

//--- pkg/sep_if.sv
// serial lines between host end and device end
// all lines are levels sampled on the shared system clock
`timescale 1ns/100ps
`default_nettype none

interface sep_if;
  logic cs;
  logic serial_clock;
  logic serial_in;
  logic serial_in_oe;
  logic dout;
  logic dout_oe;

  modport dev (input cs, serial_clock, serial_in, serial_in_oe, output dout, dout_oe);
  modport host (output cs, serial_clock, serial_in, serial_in_oe, input dout, dout_oe);
endinterface

`default_nettype wire

//--- src/sep_fifo.sv
// parameterised valid/ready fifo
// single clock, async active-low reset
`timescale 1ns/100ps
`default_nettype none

module sep_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  ////////////////////////////////////////////////////////////////
  // handshakes from honest occupancy
  assign o_ready = (count != (AW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign o_data = mem[rd_ptr];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  // pointer wrap works for any depth, not only powers of two
  always_comb
  begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push)
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
    if (pop)
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage needs no reset
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_ptr] <= i_data;
  end
endmodule

`default_nettype wire

//--- src/sep_host.sv
// host end: turns user commands into serial frames, returns read words through a fifo
// assumes the device end on the same i_clk; serial clock made here by a divider
`timescale 1ns/100ps
`default_nettype none
`include "sep_map.svh"

module sep_host #(
  parameter int PROG_CYC = `SEP_PROG_CYC,
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // command request
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire sep_pkg::sep_cmd_e i_cmd,
  input wire logic [3:0] i_addr,
  input wire sep_pkg::sep_word_t i_wdata,
  output logic o_cmd_refused,
  // read data
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output sep_pkg::sep_word_t o_rd_data,
  // serial lines
  sep_if.host link
);
  import sep_pkg::*;

  typedef enum logic [2:0] {
    HS_IDLE,
    HS_SEL,
    HS_SHIFT,
    HS_RDIN,
    HS_DESEL
  } sep_host_state_e;

  localparam int HALF = `SEP_HALF_CYC;
  localparam int LOW_READ = 2 * HALF;
  localparam int LW = $clog2(PROG_CYC + LOW_READ + 1);

  sep_host_state_e state, next_state;
  logic [24:0] tx, next_tx;
  logic [4:0] cnt, next_cnt, nbits, next_nbits;
  sep_word_t rx, next_rx;
  logic cs, next_cs, sck, next_sck, si, next_si, si_oe, next_si_oe;
  logic is_rd, next_is_rd, is_prog, next_is_prog, refused, next_refused;
  logic [LW-1:0] low_cnt, next_low_cnt;
  logic [$clog2(HALF)-1:0] div, next_div;
  logic tick, push, fifo_ready;
  logic [8:0] frame;

  ////////////////////////////////////////////////////////////////
  // half-period enable: 50% duty at 250 kHz
  assign tick = (div == '0);
  always_comb
  begin
    next_div = tick ? ($clog2(HALF))'(HALF - 1) : div - 1'b1;
  end

  // frame for the request: start bit, opcode nibble, address or sub-code
  always_comb
  begin
    frame = {1'b1, `SEP_OPC_READ, i_addr};
    unique case (i_cmd)
      SEP_CMD_READ: frame = {1'b1, `SEP_OPC_READ, i_addr};
      SEP_CMD_WRITE: frame = {1'b1, `SEP_OPC_WRITE, i_addr};
      SEP_CMD_ERASE: frame = {1'b1, `SEP_OPC_ERASE, i_addr};
      SEP_CMD_CLEAR_ALL: frame = {1'b1, `SEP_OPC_SPECIAL, `SEP_CLEAR_ALL_CMD};
      SEP_CMD_PROGRAM_ALL: frame = {1'b1, `SEP_OPC_SPECIAL, `SEP_PROGRAM_ALL_CMD};
      SEP_CMD_PROG_EN: frame = {1'b1, `SEP_OPC_SPECIAL, `SEP_PROGRAM_ENABLE_CMD};
      SEP_CMD_PROG_DIS: frame = {1'b1, `SEP_OPC_SPECIAL, `SEP_PROGRAM_DISABLE_CMD};
      default: frame = {1'b1, `SEP_OPC_READ, i_addr};
    endcase
  end

  // a read is only started when its word is sure to fit in the fifo
  assign o_cmd_ready = (state == HS_IDLE) && fifo_ready;

  ////////////////////////////////////////////////////////////////
  // frame sequencer
  always_comb
  begin
    next_state = state;
    next_tx = tx;
    next_cnt = cnt;
    next_nbits = nbits;
    next_rx = rx;
    next_cs = cs;
    next_sck = sck;
    next_si = si;
    next_si_oe = si_oe;
    next_is_rd = is_rd;
    next_is_prog = is_prog;
    next_low_cnt = low_cnt;
    next_refused = 1'b0;
    push = 1'b0;
    unique case (state)
      HS_IDLE:
      begin
        if (i_cmd_valid && o_cmd_ready)
        begin
          if (i_cmd == SEP_CMD_PROGRAM_ALL)
            next_refused = 1'b1;
          else
          begin
            next_tx = {frame, i_wdata};
            next_nbits = (i_cmd == SEP_CMD_WRITE) ? 5'(`SEP_CMD_BITS + `SEP_DATA_BITS) : 5'(`SEP_CMD_BITS);
            next_is_rd = (i_cmd == SEP_CMD_READ);
            next_is_prog = (i_cmd == SEP_CMD_WRITE) || (i_cmd == SEP_CMD_ERASE) || (i_cmd == SEP_CMD_CLEAR_ALL);
            next_cs = 1'b1;
            next_si = 1'b0;
            next_si_oe = 1'b1;
            next_cnt = '0;
            next_state = HS_SEL;
          end
        end
      end
      HS_SEL:
      begin
        // line low first, so the start bit is a zero-to-one step
        if (tick)
        begin
          next_si = tx[24];
          next_tx = {tx[23:0], 1'b0};
          next_state = HS_SHIFT;
        end
      end
      HS_SHIFT:
      begin
        if (tick && !sck)
        begin
          next_sck = 1'b1;
          next_cnt = cnt + 5'd1;
          // a read hands the line over at its last rise, before the device answers
          if (is_rd && cnt == nbits - 5'd1)
            next_si_oe = 1'b0;
        end
        else if (tick)
        begin
          next_sck = 1'b0;
          if (cnt == nbits)
          begin
            next_si = 1'b0;
            next_si_oe = 1'b0;
            next_cnt = '0;
            next_state = is_rd ? HS_RDIN : HS_DESEL;
          end
          else
          begin
            next_si = tx[24];
            next_tx = {tx[23:0], 1'b0};
          end
        end
      end
      HS_RDIN:
      begin
        if (tick && !sck)
        begin
          next_sck = 1'b1;
          next_rx = {rx[14:0], link.dout};
          next_cnt = cnt + 5'd1;
        end
        else if (tick && cnt == 5'(`SEP_READ_OUT_BITS))
        begin
          next_sck = 1'b0;
          push = 1'b1;
          next_state = HS_DESEL;
        end
        else if (tick)
          next_sck = 1'b0;
      end
      HS_DESEL:
      begin
        // clock held low while deselected
        next_cs = 1'b0;
        next_low_cnt = low_cnt + LW'(1);
        if (low_cnt == (is_prog ? LW'(PROG_CYC - 1) : LW'(LOW_READ - 1)))
        begin
          next_low_cnt = '0;
          next_state = HS_IDLE;
        end
      end
      default:
        next_state = HS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state <= HS_IDLE;
      tx <= '0;
      cnt <= '0;
      nbits <= '0;
      rx <= '0;
      cs <= 1'b0;
      sck <= 1'b0;
      si <= 1'b0;
      si_oe <= 1'b0;
      is_rd <= 1'b0;
      is_prog <= 1'b0;
      low_cnt <= '0;
      refused <= 1'b0;
      div <= '0;
    end
    else
    begin
      state <= next_state;
      tx <= next_tx;
      cnt <= next_cnt;
      nbits <= next_nbits;
      rx <= next_rx;
      cs <= next_cs;
      sck <= next_sck;
      si <= next_si;
      si_oe <= next_si_oe;
      is_rd <= next_is_rd;
      is_prog <= next_is_prog;
      low_cnt <= next_low_cnt;
      refused <= next_refused;
      div <= next_div;
    end
  end

  ////////////////////////////////////////////////////////////////
  // read words queue for the user; a full queue stalls new commands
  sep_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) u_rd_fifo (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_valid(push),
    .o_ready(fifo_ready),
    .i_data(rx),
    .o_valid(o_rd_valid),
    .i_ready(i_rd_ready),
    .o_data(o_rd_data)
  );

  assign link.cs = cs;
  assign link.serial_clock = sck;
  assign link.serial_in = si;
  assign link.serial_in_oe = si_oe;
  assign o_cmd_refused = refused;
endmodule

`default_nettype wire

//--- tb/sep_chk.sv
// checker for the serial lines between host end and device end
// assumes every line is a level sampled on the shared i_clk
`timescale 1ns/100ps
`default_nettype none

module sep_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // serial lines
  input wire logic cs,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic serial_in_oe,
  input wire logic dout,
  input wire logic dout_oe
);
  logic [15:0] hi_cnt;
  logic [15:0] lo_cnt;
  logic [15:0] next_hi_cnt;
  logic [15:0] next_lo_cnt;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  ////////////////////////////////////////////////////////////////////////////////
  // clock-high and select-low run lengths; low count saturates so reset reads as long idle
  always_comb
  begin
    next_hi_cnt = serial_clock ? hi_cnt + 16'h0001 : 16'h0000;
    next_lo_cnt = cs ? 16'h0000 : ((lo_cnt == 16'hFFFF) ? lo_cnt : lo_cnt + 16'h0001);
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      hi_cnt <= 16'h0000;
      lo_cnt <= 16'hFFFF;
    end
    else
    begin
      hi_cnt <= next_hi_cnt;
      lo_cnt <= next_lo_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // line relations
  sck_idle_low_a: assert property (!cs |-> !serial_clock)
    else $error("serial clock high while deselected");
  out_unselected_a: assert property (!cs |-> !dout_oe)
    else $error("device output driven while deselected");
  no_contention_a: assert property (!(serial_in_oe && dout_oe))
    else $error("both program_disable_cmd_alias drive data at once");
  in_stable_high_a: assert property (serial_clock && $past(serial_clock) |-> $stable(serial_in))
    else $error("serial input moved while clock high");
  sck_high_time_a: assert property ($fell(serial_clock) |-> hi_cnt == 16'd200)
    else $error("serial clock high time wrong");
  select_gap_a: assert property ($rose(cs) |-> lo_cnt >= 16'd400)
    else $error("select low too short before next frame");
  start_bit_a: assert property ($rose(cs) |-> !serial_clock throughout (!serial_in ##[1:400] serial_in))
    else $error("no zero-to-one start bit after select");
  dummy_zero_a: assert property ($rose(dout_oe) |-> !dout && cs && !serial_in_oe)
    else $error("read output does not open with zero");
  out_after_rise_a: assert property ($rose(dout_oe) |-> serial_clock && !$past(serial_clock, 4))
    else $error("read output not tied to clock rise");

  // main scenarios reached
  cover property ($rose(dout_oe));
  cover property ($fell(serial_in_oe));
  cover property ($fell(cs) ##1 !cs[*8]);
endmodule

`default_nettype wire

//--- tb/serial_eeprom_command_port_tb.sv
// testbench: host end and device end joined, plus a second device driven by hand
// assumes 100 MHz i_clk and the sep_pkg types
`timescale 1ns/100ps
`default_nettype none

module serial_eeprom_command_port_tb;
  import sep_pkg::*;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic cmd_valid = 1'b0;
  logic rd_ready = 1'b0;
  sep_cmd_e cmd = SEP_CMD_READ;
  logic [3:0] addr = 4'h0;
  sep_word_t wdata = 16'h0000;
  sep_word_t rd_data;
  logic cmd_ready, cmd_refused, rd_valid, prog_en, hv_on, prog_en_b, hv_on_b;
  logic sck_q = 1'b0;
  logic cs_q = 1'b0;
  logic [31:0] rises = 32'h0;
  logic [31:0] bits = 32'h0;
  int mismatches = 0;
  int cmp_count = 0;
  sep_if link ();
  sep_if link_b ();

  always #5 i_clk = ~i_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // short programming pulse and a two-word buffer keep the run short
  sep_host #(.PROG_CYC(2000), .FIFO_DEPTH(2)) u_sep_host (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd(cmd), .i_addr(addr), .i_wdata(wdata),
    .o_cmd_refused(cmd_refused), .o_rd_valid(rd_valid), .i_rd_ready(rd_ready), .o_rd_data(rd_data), .link(link));
  sep_dev u_sep_dev (.i_clk(i_clk), .i_nrst(i_nrst), .link(link), .o_prog_en(prog_en), .o_hv_on(hv_on));
  sep_dev u_sep_dev_b (.i_clk(i_clk), .i_nrst(i_nrst), .link(link_b), .o_prog_en(prog_en_b), .o_hv_on(hv_on_b));
  sep_chk u_sep_chk (.i_clk(i_clk), .i_nrst(i_nrst), .cs(link.cs), .serial_clock(link.serial_clock),
    .serial_in(link.serial_in), .serial_in_oe(link.serial_in_oe), .dout(link.dout), .dout_oe(link.dout_oe));

  // host bits seen at each clock rise of the current frame
  always @(posedge i_clk)
  begin
    sck_q <= link.serial_clock;
    cs_q <= link.cs;
    if (link.cs && !cs_q)
      rises <= 32'h0;
    else if (link.cs && link.serial_clock && !sck_q)
    begin
      rises <= rises + 32'h1;
      bits <= {bits[30:0], link.serial_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // bounded wait on select (sel 0) or command ready (sel 1)
  task automatic wait_lvl(input int sel, input logic lvl);
    int n = 0;
    while (((sel == 0) ? link.cs : cmd_ready) !== lvl)
    begin
      @(negedge i_clk);
      n++;
      if (n > 20000)
      begin
        mismatches++;
        final_report();
      end
    end
  endtask

  // one command through the host; full means the buffer should then hold command ready low
  task automatic run(input sep_cmd_e c, input logic [3:0] a, input sep_word_t d, input logic hv, input logic full);
    logic r;
    cmd = c;
    addr = a;
    wdata = d;
    cmd_valid = 1'b1;
    wait_lvl(1, 1'b1);
    @(negedge i_clk);
    cmd_valid = 1'b0;
    r = cmd_refused;
    check("refused", r, c == SEP_CMD_PROGRAM_ALL);
    if (!r)
    begin
      wait_lvl(0, 1'b1);
      wait_lvl(0, 1'b0);
      repeat (3) @(negedge i_clk);
      check("hv_on", hv_on, hv);
      if (full)
      begin
        repeat (500) @(negedge i_clk);
        check("ready_full", cmd_ready, 1'b0);
      end
      else
        wait_lvl(1, 1'b1);
    end
    else
      @(negedge i_clk);
  endtask

  task automatic drain(input sep_word_t exp);
    check("rd_valid", rd_valid, 1'b1);
    check("rd_data", rd_data, exp);
    rd_ready = 1'b1;
    @(negedge i_clk);
    rd_ready = 1'b0;
    // an edge passes so a following drain never retoggles ready in one step
    @(negedge i_clk);
  endtask

  // hand-made frame on the second link, far faster than the host's serial clock but well inside the device's reach
  task automatic bang(input logic [8:0] b);
    for (int i = 8; i >= 0; i--)
    begin
      link_b.serial_in = b[i];
      repeat (4) @(negedge i_clk);
      link_b.serial_clock = 1'b1;
      repeat (4) @(negedge i_clk);
      link_b.serial_clock = 1'b0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    link_b.cs = 1'b0;
    link_b.serial_clock = 1'b0;
    link_b.serial_in = 1'b0;
    link_b.serial_in_oe = 1'b0;
    repeat (12) @(negedge i_clk);
    i_nrst = 1'b1;
    @(negedge i_clk);
    link_b.cs = 1'b1;
    @(negedge i_clk);
    bang(9'h1C1);
    bang(9'h1C2);
    link_b.cs = 1'b0;
    repeat (4) @(negedge i_clk);
    check("one_instr", prog_en_b, 1'b1);
    link_b.cs = 1'b1;
    @(negedge i_clk);
    bang(9'h1C2);
    link_b.cs = 1'b0;
    repeat (4) @(negedge i_clk);
    check("disable_b", prog_en_b, 1'b0);
    run(SEP_CMD_PROG_EN, 4'h0, 16'h0000, 1'b0, 1'b0);
    check("prog_en", prog_en, 1'b1);
    run(SEP_CMD_WRITE, 4'hF, 16'hA5C3, 1'b1, 1'b0);
    check("write_bits", {7'h00, bits[24:0]}, {7'h00, 1'b1, 4'h8, 4'hF, 16'hA5C3});
    check("write_rises", rises, 32'd25);
    run(SEP_CMD_READ, 4'hF, 16'h0000, 1'b0, 1'b0);
    check("read_rises", rises, 32'd26);
    run(SEP_CMD_PROGRAM_ALL, 4'h0, 16'h0000, 1'b0, 1'b0);
    run(SEP_CMD_PROG_DIS, 4'h0, 16'h0000, 1'b0, 1'b0);
    check("prog_dis", prog_en, 1'b0);
    run(SEP_CMD_WRITE, 4'hF, 16'h1234, 1'b0, 1'b0);
    run(SEP_CMD_READ, 4'hF, 16'h0000, 1'b0, 1'b1);
    drain(16'hA5C3);
    drain(16'hA5C3);
    check("drained", rd_valid, 1'b0);
    wait_lvl(1, 1'b1);
    run(SEP_CMD_PROG_EN, 4'h0, 16'h0000, 1'b0, 1'b0);
    run(SEP_CMD_ERASE, 4'hF, 16'h0000, 1'b1, 1'b0);
    run(SEP_CMD_READ, 4'hF, 16'h0000, 1'b0, 1'b0);
    drain(16'hFFFF);
    run(SEP_CMD_CLEAR_ALL, 4'h0, 16'h0000, 1'b1, 1'b0);
    run(SEP_CMD_READ, 4'h3, 16'h0000, 1'b0, 1'b0);
    drain(16'hFFFF);
    final_report();
  end
endmodule

`default_nettype wire
